// *** logic/sioexp_core.sv ***
// Serial peripheral that decodes three-byte commands onto an 8-bit port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The link only acts while the select line is low; high disables it.
// - The serial clock idles high between transfers.
// - Data changes on the first clock edge of a bit, is sampled on the next.
// - Characters are eight bits, most significant bit first.
// - Codes 0 to 6: clear, set all, set group, set bit, read all/group/bit.
// - The port splits into groups of bits 3-0, 5-4 and 7-6.
// - Group and bit commands use the index byte, valid 0x00 to 0x02 for groups, 0x00 to 0x07 for bits.
// - Clear all, set all and read all ignore the index byte.
// - Set all copies data bits D7..D0 to port bits 7..0.
// - Set group writes the group from low data bits, set bit writes only D0.
// - Clear all and every read ignore the data byte.
// - Set bit changes only the pin named by the index, to data bit 0.
module sioexp_core
  import sioexp_pkg::*;
#(
  parameter int unsigned P_PORT_W = PORT_W
) (
  input  wire logic                clk_in,                  // System clock
  input  wire logic                rst_n_in,                // Async reset
  input  wire logic                serial_shift_clock_in,   // Host clock
  input  wire logic                peripheral_select_n_in,  // Select, low
  input  wire logic                mosi_in,                 // Host data
  input  wire logic [P_PORT_W-1:0] io_in,                   // Port pins in
  output logic                     miso_out,                // Reply data
  output logic                     miso_oe_out,             // Reply enable
  output logic [P_PORT_W-1:0]      port_out                 // Port pins out
);

  // The command set addresses exactly eight bits in fixed groups
  if (P_PORT_W != PORT_W) begin : g_bad_width
    $error("sioexp_core supports an 8-bit port only");
  end

  // ==========================================================
  // Decoding helpers
  function automatic logic [7:0] grp_mask(input logic [7:0] idx);
    unique case (idx)
      8'h00:   grp_mask = GRP0_MASK;
      8'h01:   grp_mask = GRP1_MASK;
      8'h02:   grp_mask = GRP2_MASK;
      default: grp_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] grp_lsb(input logic [7:0] idx);
    unique case (idx)
      8'h01:   grp_lsb = GRP1_LSB;
      8'h02:   grp_lsb = GRP2_LSB;
      default: grp_lsb = GRP0_LSB;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic       sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
  logic       sel_s1_ff, sel_s2_ff;
  logic       mosi_s1_ff, mosi_s2_ff;
  logic [7:0] io_s1_ff, io_s2_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_s1_ff <= 1'b1;
      sclk_s2_ff <= 1'b1;
      sclk_d_ff  <= 1'b1;
      sel_s1_ff  <= 1'b1;
      sel_s2_ff  <= 1'b1;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
      io_s1_ff   <= 8'h00;
      io_s2_ff   <= 8'h00;
    end else begin
      sclk_s1_ff <= serial_shift_clock_in;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff  <= sclk_s2_ff;
      sel_s1_ff  <= peripheral_select_n_in;
      sel_s2_ff  <= sel_s1_ff;
      mosi_s1_ff <= mosi_in;
      mosi_s2_ff <= mosi_s1_ff;
      io_s1_ff   <= io_in;
      io_s2_ff   <= io_s1_ff;
    end
  end

  logic active;
  logic sclk_fall;
  logic sclk_rise;
  assign active    = ~sel_s2_ff;
  // Idle-high clock: falling edge opens a bit, rising edge samples it
  assign sclk_fall = active & sclk_d_ff & ~sclk_s2_ff;
  assign sclk_rise = active & ~sclk_d_ff & sclk_s2_ff;

  // ==========================================================
  // Receive shifter and message framing
  logic [3:0]    bit_cnt_ff;
  logic [7:0]    rx_ff;
  logic [7:0]    cmd_ff;
  logic [7:0]    idx_ff;
  sioexp_phase_t phase_ff;
  logic [7:0]    nxt_rx;
  logic          byte_done;
  logic          exec;

  assign nxt_rx    = {rx_ff[6:0], mosi_s2_ff};
  assign byte_done = sclk_rise && (bit_cnt_ff == CHAR_LAST);
  assign exec      = byte_done && (phase_ff == SIOEXP_PH_DATA);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_ff <= 4'h0;
      rx_ff      <= 8'h00;
    end else if (!active) begin
      // Deselect drops any partial character
      bit_cnt_ff <= 4'h0;
    end else if (sclk_rise) begin
      rx_ff      <= nxt_rx;
      bit_cnt_ff <= byte_done ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_ff <= SIOEXP_PH_CMD;
      cmd_ff   <= 8'h00;
      idx_ff   <= 8'h00;
    end else if (!active) begin
      phase_ff <= SIOEXP_PH_CMD;
    end else if (byte_done) begin
      unique case (phase_ff)
        SIOEXP_PH_CMD: begin
          cmd_ff   <= nxt_rx;
          phase_ff <= SIOEXP_PH_IDX;
        end
        SIOEXP_PH_IDX: begin
          idx_ff   <= nxt_rx;
          phase_ff <= SIOEXP_PH_DATA;
        end
        SIOEXP_PH_DATA: begin
          // Further bytes in the same select start a new message
          phase_ff <= SIOEXP_PH_CMD;
        end
        default: phase_ff <= SIOEXP_PH_CMD;
      endcase
    end
  end

  // ==========================================================
  // Command execution on the port
  logic [7:0] gmask;
  logic [2:0] glsb;
  logic [7:0] bit_sel;
  logic       idx_ok;

  assign gmask   = grp_mask(idx_ff);
  assign glsb    = grp_lsb(idx_ff);
  assign idx_ok  = (idx_ff <= IDX_MAX);
  assign bit_sel = idx_ok ? (8'h01 << idx_ff[2:0]) : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_out <= PORT_RST;
    end else if (exec) begin
      unique case (cmd_ff)
        CMD_CLR_ALL: port_out <= 8'h00;
        CMD_SET_ALL: port_out <= nxt_rx;
        CMD_SET_GRP: port_out <= (port_out & ~gmask) |
                                 ((nxt_rx << glsb) & gmask);
        CMD_SET_BIT: port_out <= (port_out & ~bit_sel) |
                                 ({8{nxt_rx[0]}} & bit_sel);
        default:     port_out <= port_out;
      endcase
    end
  end

  // ==========================================================
  // Read reply and transmit shifter
  // The reply is held across deselect so the host may fetch it with
  // the first byte of its next frame as well as with a fourth byte.
  logic [7:0] tx_ff;
  logic [7:0] rd_val;

  always_comb begin
    unique case (cmd_ff)
      CMD_RD_ALL: rd_val = io_s2_ff;
      CMD_RD_GRP: rd_val = (io_s2_ff & gmask) >> glsb;
      CMD_RD_BIT: rd_val = {7'h00, |(io_s2_ff & bit_sel)};
      default:    rd_val = TX_RST;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_ff    <= TX_RST;
      miso_out <= 1'b0;
    end else if (exec && (cmd_ff >= CMD_RD_ALL) &&
                 (cmd_ff <= CMD_RD_BIT)) begin
      tx_ff    <= rd_val;
    end else if (sclk_fall) begin
      // New bit goes out on the first edge of its period
      miso_out <= tx_ff[7];
      tx_ff    <= {tx_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      miso_oe_out <= 1'b0;
    end else begin
      miso_oe_out <= active;
    end
  end

endmodule
`default_nettype wire

// *** shared/sioexp_pkg.sv ***
// Constants shared by the serial I/O expander command block
`default_nettype none
package sioexp_pkg;
  // ==========================================================
  // Port and character layout
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned CHAR_W    = 8;
  localparam logic [3:0]  CHAR_LAST = 4'h7;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_CLR_ALL = 8'h00;
  localparam logic [7:0] CMD_SET_ALL = 8'h01;
  localparam logic [7:0] CMD_SET_GRP = 8'h02;
  localparam logic [7:0] CMD_SET_BIT = 8'h03;
  localparam logic [7:0] CMD_RD_ALL  = 8'h04;
  localparam logic [7:0] CMD_RD_GRP  = 8'h05;
  localparam logic [7:0] CMD_RD_BIT  = 8'h06;
  // ==========================================================
  // Group layout: index 0, 1, 2 select the three fixed groups
  localparam logic [7:0] GRP0_MASK = 8'h0f;
  localparam logic [7:0] GRP1_MASK = 8'h30;
  localparam logic [7:0] GRP2_MASK = 8'hc0;
  localparam logic [2:0] GRP0_LSB  = 3'h0;
  localparam logic [2:0] GRP1_LSB  = 3'h4;
  localparam logic [2:0] GRP2_LSB  = 3'h6;
  localparam logic [7:0] IDX_MAX   = 8'h07;
  // ==========================================================
  // Reset values
  localparam logic [7:0] PORT_RST  = 8'h00;
  localparam logic [7:0] TX_RST    = 8'h00;
  // ==========================================================
  // Byte position inside a three-byte message
  typedef enum logic [2:0] {
    SIOEXP_PH_CMD  = 3'b001,
    SIOEXP_PH_IDX  = 3'b010,
    SIOEXP_PH_DATA = 3'b100
  } sioexp_phase_t;
endpackage
`default_nettype wire

// *** verif/sioexp_host.sv ***
// Host controller model that sends messages of up to three bytes
`timescale 1ns/1ps
`default_nettype none
module sioexp_host (
  output var logic sclk_out,  // Serial clock
  output var logic sel_n_out, // Select, low
  output var logic mosi_out,  // Host data
  input wire logic miso_in    // Reply data
);
  initial begin
    sclk_out = 1'b1;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Entered at a system clock fall; each serial clock half lasts four periods of it
  task automatic xfer(input logic [23:0] tx, input int nb,
                      output logic [23:0] rx);
    rx = 24'h000000;
    sel_n_out = 1'b0;
    #400;
    for (int i = 23; i > 23 - nb; i--) begin
      sclk_out = 1'b0;
      mosi_out = tx[i];
      #100;
      sclk_out = 1'b1;
      #90;
      rx[i] = miso_in; // Late sample: reply lags the fall by sync delay
      #10;
    end
    #300;
    sel_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line shows no stale bit
    #400;
  endtask
endmodule
`default_nettype wire

// *** verif/sioexp_properties.sv ***
// Port-level checks for the serial I/O expander command block
`timescale 1ns/1ps
`default_nettype none
module sioexp_chk #(
  parameter int unsigned P_PORT_W = 8
) (
  input wire logic                clk_in,                 // System clock
  input wire logic                rst_n_in,               // Async reset
  input wire logic                serial_shift_clock_in,  // Host clock
  input wire logic                peripheral_select_n_in, // Select, low
  input wire logic                miso_out,               // Reply data
  input wire logic                miso_oe_out,            // Reply enable
  input wire logic [P_PORT_W-1:0] port_out                // Port pins
);
  wire sel_n = peripheral_select_n_in;
  wire sck   = serial_shift_clock_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Select, drive enable and port timing
  property p_oe_on; $fell(sel_n) |-> ##[1:6] miso_oe_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_off; $rose(sel_n) |-> ##[1:6] !miso_oe_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  property p_oe_idle; sel_n [*5] |-> !miso_oe_out; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
  property p_port_idle; sel_n [*8] |-> $stable(port_out); endproperty
  a_port_idle: assert property (p_port_idle) else $error("port idle");
  property p_port_sel; $changed(port_out) |-> !$past(sel_n, 4); endproperty
  a_port_sel: assert property (p_port_sel) else $error("port sel");
  // Updates follow a rising edge, never a falling one
  property p_port_rise; $changed(port_out) |-> $past(sck, 2); endproperty
  a_port_rise: assert property (p_port_rise) else $error("port edge");
  property p_miso_fall;
    $changed(miso_out) && miso_oe_out && $past(miso_oe_out) |-> !sck;
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso edge");
  property p_rst; $rose(rst_n_in) |-> port_out == '0 && !miso_oe_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
endmodule
bind sioexp_core sioexp_chk #(.P_PORT_W(P_PORT_W)) chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in),
  .serial_shift_clock_in(serial_shift_clock_in),
  .peripheral_select_n_in(peripheral_select_n_in), .miso_out(miso_out),
  .miso_oe_out(miso_oe_out), .port_out(port_out));
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the serial I/O expander command block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in, rst_n_in, sck, sel_n, mosi, miso, miso_oe;
  logic [7:0] io_pins, port_pins;
  logic [23:0] rx;
  int mismatches, tests_run;
  sioexp_core dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .serial_shift_clock_in(sck), .peripheral_select_n_in(sel_n),
    .mosi_in(mosi), .io_in(io_pins), .miso_out(miso),
    .miso_oe_out(miso_oe), .port_out(port_pins));
  sioexp_host host_u (.sclk_out(sck), .sel_n_out(sel_n),
    .mosi_out(mosi), .miso_in(miso));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [23:0] tx, input int nb);
    @(negedge clk_in);
    host_u.xfer(tx, nb, rx);
  endtask
  task automatic t_set();
    logic [31:0] t [11] = '{32'h015aa5a5, 32'h0302fea1, 32'h030601e1,
      32'h0200f6e6, 32'h020101d6, 32'h02020016, 32'h0203ff16,
      32'h03080116, 32'h0700ff16, 32'h0033ff00, 32'h0100ffff};
    foreach (t[i]) begin
      send(t[i][31:8], 24);
      chk("port", t[i][7:0], port_pins);
    end
    $display("set commands done");
  endtask
  task automatic t_read();
    logic [23:0] t [9] = '{24'h0433ff, 24'h0500ff, 24'h05015a,
      24'h0502ff, 24'h050300, 24'h0607ff, 24'h0603ff, 24'h0609ff,
      24'h070000};
    logic [7:0] e [9] = '{8'h00, 8'hb6, 8'h06, 8'h03, 8'h02, 8'h00,
      8'h01, 8'h00, 8'h00};
    io_pins = 8'hb6;
    foreach (t[i]) begin
      send(t[i], 24);
      chk("reply", e[i], rx[23:16]);
    end
    chk("port", 8'hff, port_pins);
    $display("read commands done");
  endtask
  task automatic t_abort();
    send(24'h0100ff, 12);
    send(24'h030000, 24);
    chk("port", 8'hfe, port_pins);
    chk("oe", 8'h00, {7'h00, miso_oe});
    $display("aborted message done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    rst_n_in = 1'b0;
    io_pins = 8'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_set();
    t_read();
    t_abort();
    summarize();
  end
  // About 22 messages of 6 us each; a hang is cut well beyond that
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
